// *** src/led_pwm_pkg.sv ***
package led_pwm_pkg;

  // ==========================================================
  // channel geometry
  localparam int NumChannels = 8;
  localparam int LevelWidth = 5;
  localparam int DutyWidth = 6;
  localparam int CodeWidth = 8;
  localparam int CurrentWidth = 10;

  // ==========================================================
  // timing
  localparam int ClockKhz = 40000;
  localparam int PwmPeriodNs = 575000;
  localparam int PwmSteps = 64;
  // cycles per pwm step, rounded down: 359
  localparam int StepCycles = (PwmPeriodNs / 25) / PwmSteps;
  localparam int StepCountWidth = 9;
  localparam int IdleEntryMs = 5;
  localparam int IdleEntryCycles = IdleEntryMs * ClockKhz;
  localparam int WakeMaxUs = 1000;
  localparam int WakeCycles = (WakeMaxUs * ClockKhz) / 1000;
  localparam int SettleUs = 50;
  localparam int SettleCycles = (SettleUs * ClockKhz) / 1000;
  localparam int TimerWidth = 18;

  // ==========================================================
  // global update commands on the control bits
  localparam logic [2:0] CmdUpdate = 3'h0;
  localparam logic [2:0] CmdWriteUpdate = 3'h2;

  // ==========================================================
  // charge pump gain modes, gray along the step-up path
  typedef enum logic [1:0] {
    PumpX1 = 2'h0,
    PumpX133 = 2'h1,
    PumpX15 = 2'h3,
    PumpX2 = 2'h2
  } pump_mode_t;

  // log current table, full scale code 31 maps to 1023
  localparam logic [CurrentWidth-1:0] ZeroScaleCurrent = 10'h01D;

endpackage

// *** src/log_level_dac.sv ***
`timescale 1ns/1ps
module log_level_dac
  import led_pwm_pkg::*;
(
  input wire logic [LevelWidth-1:0] levelCode,
  output logic [CurrentWidth-1:0] currentSet
);

  // ==========================================================
  // logarithmic code to current, roughly 12.2 % per step
  always_comb begin
    case (levelCode)
      5'h00: currentSet = ZeroScaleCurrent;
      5'h01: currentSet = 10'h020;
      5'h02: currentSet = 10'h024;
      5'h03: currentSet = 10'h029;
      5'h04: currentSet = 10'h02E;
      5'h05: currentSet = 10'h033;
      5'h06: currentSet = 10'h039;
      5'h07: currentSet = 10'h040;
      5'h08: currentSet = 10'h048;
      5'h09: currentSet = 10'h051;
      5'h0A: currentSet = 10'h05B;
      5'h0B: currentSet = 10'h066;
      5'h0C: currentSet = 10'h072;
      5'h0D: currentSet = 10'h080;
      5'h0E: currentSet = 10'h090;
      5'h0F: currentSet = 10'h0A1;
      5'h10: currentSet = 10'h0B5;
      5'h11: currentSet = 10'h0CB;
      5'h12: currentSet = 10'h0E4;
      5'h13: currentSet = 10'h100;
      5'h14: currentSet = 10'h11F;
      5'h15: currentSet = 10'h142;
      5'h16: currentSet = 10'h169;
      5'h17: currentSet = 10'h195;
      5'h18: currentSet = 10'h1C6;
      5'h19: currentSet = 10'h1FD;
      5'h1A: currentSet = 10'h23A;
      5'h1B: currentSet = 10'h27F;
      5'h1C: currentSet = 10'h2CC;
      5'h1D: currentSet = 10'h322;
      5'h1E: currentSet = 10'h384;
      default: currentSet = 10'h3FF;
    endcase
  end

endmodule

// *** src/led_channel_pwm_pump_ctrl.sv ***
// Function
// - eight channels, each with its own 5-bit level code to a DAC
// - level codes map to currents on a logarithmic scale
// - code 31 is full scale, code 0 is minimum nonzero current
// - each channel has its own 6-bit duty code
// - pwm period about 575 us, on time is duty code / 64 times period
// - pump starts in 1x after reset and stays while regulated
// - pump mode chosen from headroom of active channels only
// - from 1x, lost regulation in an active channel moves to 1.33x
// - from 1.33x, lost regulation steps up to 1.5x
// - from 1.5x, lost regulation steps up to 2x
// - in boosted modes, 1x sufficiency returns directly to 1x
// - low power after about 5 ms with outputs off and bus idle
// - addressed bus traffic wakes the device within 1 ms
// - written level and duty are held until a global update
// - global update applies on/off mask with level and duty
`timescale 1ns/1ps
module led_channel_pwm_pump_ctrl
  import led_pwm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic regWrite,
  input wire logic [2:0] regChannel,
  input wire logic writeLevel,
  input wire logic writeDuty,
  input wire logic writeAllLevels,
  input wire logic writeAllDuties,
  input wire logic writeOnMask,
  input wire logic [CodeWidth-1:0] regData,
  input wire logic cmdValid,
  input wire logic [2:0] cmdBits,
  input wire logic busAddressed,
  input wire logic [NumChannels-1:0] sinkRegulated,
  input wire logic [NumChannels-1:0] unityHeadroomOk,
  output logic [NumChannels-1:0] current_sink_outputs,
  output logic [NumChannels*CurrentWidth-1:0] sinkCurrentSet,
  output pump_mode_t pump_output_rail,
  output logic lowPower,
  output logic [NumChannels-1:0] activeMask
);

  // ==========================================================
  // pin synchronisers for analog comparator flags
  logic [NumChannels-1:0] regMeta_q, regSync_q;
  logic [NumChannels-1:0] headMeta_q, headSync_q;

  // two flops before any use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regMeta_q <= '1;
      regSync_q <= '1;
      headMeta_q <= '0;
      headSync_q <= '0;
    end else begin
      regMeta_q <= sinkRegulated;
      regSync_q <= regMeta_q;
      headMeta_q <= unityHeadroomOk;
      headSync_q <= headMeta_q;
    end
  end

  // ==========================================================
  // shadow and active setting registers
  logic [LevelWidth-1:0] levelShadow_q [NumChannels];
  logic [LevelWidth-1:0] levelShadow_d [NumChannels];
  logic [DutyWidth-1:0] dutyShadow_q [NumChannels];
  logic [DutyWidth-1:0] dutyShadow_d [NumChannels];
  logic [LevelWidth-1:0] levelLive_q [NumChannels];
  logic [LevelWidth-1:0] levelLive_d [NumChannels];
  logic [DutyWidth-1:0] dutyLive_q [NumChannels];
  logic [DutyWidth-1:0] dutyLive_d [NumChannels];
  logic [NumChannels-1:0] maskShadow_q, maskShadow_d;
  logic [NumChannels-1:0] maskLive_q, maskLive_d;
  logic globalUpdate;

  // update on command 000 or 010
  assign globalUpdate = cmdValid &&
    (cmdBits == CmdUpdate || cmdBits == CmdWriteUpdate);

  // shadow writes, then copy to live on update
  always_comb begin
    maskShadow_d = maskShadow_q;
    maskLive_d = maskLive_q;
    if (regWrite && writeOnMask) begin
      maskShadow_d = regData;
    end
    for (int i = 0; i < NumChannels; i++) begin
      levelShadow_d[i] = levelShadow_q[i];
      dutyShadow_d[i] = dutyShadow_q[i];
      if (regWrite && (writeAllLevels ||
          (writeLevel && regChannel == i[2:0]))) begin
        levelShadow_d[i] = regData[LevelWidth-1:0];
      end
      if (regWrite && (writeAllDuties ||
          (writeDuty && regChannel == i[2:0]))) begin
        dutyShadow_d[i] = regData[DutyWidth-1:0];
      end
      levelLive_d[i] = levelLive_q[i];
      dutyLive_d[i] = dutyLive_q[i];
      if (globalUpdate) begin
        levelLive_d[i] = levelShadow_d[i];
        dutyLive_d[i] = dutyShadow_d[i];
      end
    end
    if (globalUpdate) begin
      maskLive_d = maskShadow_d;
    end
  end

  // setting registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      maskShadow_q <= '0;
      maskLive_q <= '0;
      for (int i = 0; i < NumChannels; i++) begin
        levelShadow_q[i] <= '0;
        dutyShadow_q[i] <= '0;
        levelLive_q[i] <= '0;
        dutyLive_q[i] <= '0;
      end
    end else begin
      maskShadow_q <= maskShadow_d;
      maskLive_q <= maskLive_d;
      for (int i = 0; i < NumChannels; i++) begin
        levelShadow_q[i] <= levelShadow_d[i];
        dutyShadow_q[i] <= dutyShadow_d[i];
        levelLive_q[i] <= levelLive_d[i];
        dutyLive_q[i] <= dutyLive_d[i];
      end
    end
  end

  // ==========================================================
  // shared pwm timebase
  logic [StepCountWidth-1:0] stepDiv_q, stepDiv_d;
  logic [DutyWidth-1:0] pwmCount_q, pwmCount_d;
  logic stepTick;

  assign stepTick = (stepDiv_q == StepCountWidth'(StepCycles - 1));

  // step enable and 64-step counter, frozen in low power
  always_comb begin
    stepDiv_d = stepDiv_q;
    pwmCount_d = pwmCount_q;
    if (!lowPower) begin
      stepDiv_d = stepTick ? '0 : stepDiv_q + 1'b1;
      if (stepTick) begin
        pwmCount_d = pwmCount_q + 1'b1;
      end
    end
  end

  // timebase registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stepDiv_q <= '0;
      pwmCount_q <= '0;
    end else begin
      stepDiv_q <= stepDiv_d;
      pwmCount_q <= pwmCount_d;
    end
  end

  // ==========================================================
  // per channel output and dac
  logic [NumChannels-1:0] sinkOn_d, sinkOn_q;

  generate
    for (genvar ch = 0; ch < NumChannels; ch++) begin : gChan
      // on while counter is below duty code
      assign sinkOn_d[ch] = maskLive_q[ch] &&
        (pwmCount_q < dutyLive_q[ch]);
      log_level_dac uDac (
        .levelCode(levelLive_q[ch]),
        .currentSet(sinkCurrentSet[ch*CurrentWidth +: CurrentWidth])
      );
    end
  endgenerate

  // output flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sinkOn_q <= '0;
    end else begin
      sinkOn_q <= sinkOn_d;
    end
  end

  assign current_sink_outputs = sinkOn_q;
  assign activeMask = maskLive_q;

  // ==========================================================
  // charge pump mode sequencer
  pump_mode_t mode_q, mode_d;
  logic [TimerWidth-1:0] settle_q, settle_d;
  logic lostReg, unityOk;

  // only active channels count
  assign lostReg = |(maskLive_q & ~regSync_q);
  assign unityOk = &(headSync_q | ~maskLive_q);

  // step up or fall back after a settling dwell
  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    if (settle_q != '0) begin
      settle_d = settle_q - 1'b1;
    end else begin
      case (mode_q)
        PumpX1: begin
          if (lostReg) begin
            mode_d = PumpX133;
          end
        end
        PumpX133: begin
          if (unityOk) begin
            mode_d = PumpX1;
          end else if (lostReg) begin
            mode_d = PumpX15;
          end
        end
        PumpX15: begin
          if (unityOk) begin
            mode_d = PumpX1;
          end else if (lostReg) begin
            mode_d = PumpX2;
          end
        end
        PumpX2: begin
          if (unityOk) begin
            mode_d = PumpX1;
          end
        end
        default: mode_d = PumpX1;
      endcase
      if (mode_d != mode_q) begin
        settle_d = TimerWidth'(SettleCycles);
      end
    end
  end

  // pump registers, 1x at reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= PumpX1;
      settle_q <= '0;
    end else begin
      mode_q <= mode_d;
      settle_q <= settle_d;
    end
  end

  assign pump_output_rail = mode_q;

  // ==========================================================
  // low power entry timer
  logic [TimerWidth-1:0] idle_q, idle_d;
  logic lowPower_q, lowPower_d;

  // count idle time, wake at once on addressed traffic
  always_comb begin
    idle_d = idle_q;
    lowPower_d = lowPower_q;
    if (busAddressed || maskLive_q != '0) begin
      idle_d = '0;
      lowPower_d = 1'b0;
    end else if (idle_q == TimerWidth'(IdleEntryCycles - 1)) begin
      lowPower_d = 1'b1;
    end else begin
      idle_d = idle_q + 1'b1;
    end
  end

  // idle registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idle_q <= '0;
      lowPower_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      lowPower_q <= lowPower_d;
    end
  end

  assign lowPower = lowPower_q;

endmodule

// *** verification/led_pwm_chk.sv ***
`timescale 1ns/1ps
module led_pwm_chk
  import led_pwm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [2:0] cmdBits,
  input wire logic busAddressed,
  input wire logic [NumChannels-1:0] current_sink_outputs,
  input wire logic [NumChannels*CurrentWidth-1:0] sinkCurrentSet,
  input wire pump_mode_t pump_output_rail,
  input wire logic lowPower,
  input wire logic [NumChannels-1:0] activeMask
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ====
  // cycles since the last rail change
  logic [11:0] dwell_q, dwell_d;
  pump_mode_t prevRail_q, prevRail_d;
  always_comb begin
    prevRail_d = pump_output_rail;
    dwell_d = dwell_q;
    if (pump_output_rail != prevRail_q) begin
      dwell_d = 12'h000;
    end else if (dwell_q != 12'hFFF) begin
      dwell_d = dwell_q + 12'h001;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dwell_q <= 12'hFFF;
      prevRail_q <= PumpX1;
    end else begin
      dwell_q <= dwell_d;
      prevRail_q <= prevRail_d;
    end
  end
  // ====
  // named steps
  sequence s_wake;
    lowPower && busAddressed;
  endsequence
  sequence s_step_up;
    $past(pump_output_rail) == PumpX1 && pump_output_rail == PumpX133 ||
    $past(pump_output_rail) == PumpX133 && pump_output_rail == PumpX15 ||
    $past(pump_output_rail) == PumpX15 && pump_output_rail == PumpX2;
  endsequence
  // ====
  // properties
  a_legal_step: assert property (
    $changed(pump_output_rail) |-> (pump_output_rail == PumpX1) or s_step_up)
    else $error("illegal pump step");
  a_rail_dwell: assert property (
    $changed(pump_output_rail) |-> dwell_q >= 12'(SettleCycles))
    else $error("pump changed inside dwell");
  a_reset_unity: assert property (
    $rose(rstn) |-> pump_output_rail == PumpX1)
    else $error("pump not unity after reset");
  a_hold_live: assert property (
    !(cmdValid && (cmdBits == CmdUpdate || cmdBits == CmdWriteUpdate))
    |=> $stable(activeMask))
    else $error("mask changed without update");
  a_wake_fast: assert property (
    s_wake |=> !lowPower)
    else $error("no wake on bus traffic");
  a_busy_awake: assert property (
    activeMask != 8'h00 |=> !lowPower)
    else $error("low power with active channels");
  a_mask_gate: assert property (
    (current_sink_outputs & ~$past(activeMask)) == 8'h00)
    else $error("inactive channel driven");
  for (genvar n = 0; n < NumChannels; n++) begin : g_floor
    a_current_floor: assert property (
      sinkCurrentSet[n*CurrentWidth +: CurrentWidth] >= ZeroScaleCurrent)
      else $error("current below zero scale");
  end
endmodule
bind led_channel_pwm_pump_ctrl led_pwm_chk i_led_pwm_chk (
  .clock(clock),
  .rstn(rstn),
  .cmdValid(cmdValid),
  .cmdBits(cmdBits),
  .busAddressed(busAddressed),
  .current_sink_outputs(current_sink_outputs),
  .sinkCurrentSet(sinkCurrentSet),
  .pump_output_rail(pump_output_rail),
  .lowPower(lowPower),
  .activeMask(activeMask)
);

// *** verification/led_string_model.sv ***
`timescale 1ns/1ps
module led_string_model
  import led_pwm_pkg::*;
(
  input wire pump_mode_t railMode,
  input wire logic [NumChannels-1:0] weakMask,
  input wire logic [1:0] need,
  output logic [NumChannels-1:0] sinkRegulated,
  output logic [NumChannels-1:0] unityHeadroomOk
);
  logic [1:0] gain;
  // rank of the rail along the step-up path
  always_comb begin
    case (railMode)
      PumpX133: gain = 2'h1;
      PumpX15: gain = 2'h2;
      PumpX2: gain = 2'h3;
      default: gain = 2'h0;
    endcase
  end
  // weak strings regulate only on a high enough rail
  assign sinkRegulated = ~weakMask | {NumChannels{gain >= need}};
  assign unityHeadroomOk = ~weakMask | {NumChannels{need == 2'h0}};
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import led_pwm_pkg::*;
;
  logic clock, rstn, regWrite, writeLevel, writeDuty, writeAllLevels;
  logic writeAllDuties, writeOnMask, cmdValid, busAddressed, lowPower;
  logic [2:0] regChannel, cmdBits;
  logic [7:0] regData, weakMask, sinkRegulated, unityHeadroomOk;
  logic [7:0] current_sink_outputs, activeMask;
  logic [1:0] need;
  logic [79:0] sinkCurrentSet, curExp;
  logic [87:0] lastMask;
  logic [87:0] expMask[$];
  pump_mode_t pump_output_rail, lastRail;
  pump_mode_t expRail[$];
  int num_errors, samples_checked, hi0, hi1, w;
  led_channel_pwm_pump_ctrl i_led_channel_pwm_pump_ctrl (
    .clock(clock), .rstn(rstn), .regWrite(regWrite),
    .regChannel(regChannel), .writeLevel(writeLevel),
    .writeDuty(writeDuty), .writeAllLevels(writeAllLevels),
    .writeAllDuties(writeAllDuties), .writeOnMask(writeOnMask),
    .regData(regData), .cmdValid(cmdValid), .cmdBits(cmdBits),
    .busAddressed(busAddressed), .sinkRegulated(sinkRegulated),
    .unityHeadroomOk(unityHeadroomOk),
    .current_sink_outputs(current_sink_outputs),
    .sinkCurrentSet(sinkCurrentSet), .pump_output_rail(pump_output_rail),
    .lowPower(lowPower), .activeMask(activeMask));
  led_string_model i_led_string_model (
    .railMode(pump_output_rail), .weakMask(weakMask), .need(need),
    .sinkRegulated(sinkRegulated), .unityHeadroomOk(unityHeadroomOk));
  // ====
  // clock and shared tasks
  always #12.5 clock = ~clock;
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one front-end transfer: write strobes and/or command
  task automatic go(input logic [4:0] sel, input logic [2:0] ch,
      input logic [7:0] d, input logic cv, input logic [2:0] cb);
    regWrite <= |sel;
    {writeLevel, writeDuty, writeAllLevels, writeAllDuties, writeOnMask} <= sel;
    regChannel <= ch;
    regData <= d;
    cmdValid <= cv;
    cmdBits <= cb;
    busAddressed <= 1'b1;
    @(posedge clock);
    {regWrite, writeLevel, writeDuty, writeAllLevels} <= 4'h0;
    {writeAllDuties, writeOnMask, cmdValid, busAddressed} <= 4'h0;
    @(posedge clock);
  endtask
  // ====
  // output watcher, oldest note per change
  always @(posedge clock) begin
    if (rstn && pump_output_rail !== lastRail)
      check(pump_output_rail, expRail.size() ? expRail.pop_front() : lastRail);
    if (rstn && {activeMask, sinkCurrentSet} !== lastMask)
      check({activeMask, sinkCurrentSet},
        expMask.size() ? expMask.pop_front() : lastMask);
    lastRail = pump_output_rail;
    lastMask = {activeMask, sinkCurrentSet};
  end
  initial begin
    #(25ns * 60000);
    num_errors++;
    report_and_stop();
  end
  // ====
  // main sequence
  initial begin
    {clock, rstn, regWrite, writeLevel, writeDuty, writeAllLevels} = 6'h00;
    {writeAllDuties, writeOnMask, cmdValid, busAddressed} = 4'h0;
    {regChannel, cmdBits, regData, weakMask, need} = 24'h000000;
    void'($urandom(9696));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check(pump_output_rail, PumpX1);
    go(5'h04, 3'h0, 8'($urandom) & 8'hE0, 1'b0, 3'h0);
    go(5'h10, 3'h0, (8'($urandom) & 8'hE0) | 8'h1F, 1'b0, 3'h0);
    go(5'h02, 3'h0, (8'($urandom) & 8'hC0) | 8'h3F, 1'b0, 3'h0);
    go(5'h08, 3'h0, (8'($urandom) & 8'hC0) | 8'h20, 1'b0, 3'h0);
    go(5'h01, 3'h0, 8'h01, 1'b0, 3'h0);
    for (int c = 1; c < 8; c++) begin
      if (c != 2) go(5'h00, 3'h0, 8'($urandom), 1'b1, 3'(c));
    end
    for (int n = 0; n < NumChannels; n++) begin
      curExp[n*CurrentWidth +: CurrentWidth] = n ? ZeroScaleCurrent : 10'h3FF;
    end
    expMask.push_back({8'h01, curExp});
    go(5'h00, 3'h0, 8'h00, 1'b1, CmdUpdate);
    expMask.push_back({8'h03, curExp});
    go(5'h01, 3'h0, 8'h03, 1'b1, CmdWriteUpdate);
    $display("test settings done");
    {hi0, hi1} = 64'h0;
    repeat (StepCycles * PwmSteps) begin
      @(posedge clock);
      hi0 += current_sink_outputs[0];
      hi1 += current_sink_outputs[1];
    end
    check(hi0, 32 * StepCycles);
    check(hi1, 63 * StepCycles);
    $display("test pwm done");
    weakMask <= 8'h04;
    need <= 2'h3;
    repeat (200) @(posedge clock);
    expRail.push_back(PumpX133);
    expRail.push_back(PumpX15);
    expRail.push_back(PumpX2);
    weakMask <= 8'h01;
    for (w = 0; w < 9000 && expRail.size() > 0; w++) @(posedge clock);
    expRail.push_back(PumpX1);
    need <= 2'h0;
    for (w = 0; w < 3000 && expRail.size() > 0; w++) @(posedge clock);
    // shallower needs, 1.33x and 1.5x each fall straight back to 1x
    for (int k = 1; k < 3; k++) begin
      expRail.push_back(PumpX133);
      if (k == 2) expRail.push_back(PumpX15);
      expRail.push_back(PumpX1);
      need <= 2'(k);
      for (w = 0; w < 9000 && expRail.size() > 1; w++) @(posedge clock);
      need <= 2'h0;
      for (w = 0; w < 3000 && expRail.size() > 0; w++) @(posedge clock);
    end
    expMask.push_back({8'h00, curExp});
    go(5'h01, 3'h0, 8'h00, 1'b1, CmdWriteUpdate);
    repeat (3) @(posedge clock);
    check(expRail.size() + expMask.size(), 0);
    check(lowPower, 1'b0);
    $display("test pump done");
    report_and_stop();
  end
endmodule
